// >>> core/sfcf_dev.sv
`timescale 1ns/1ps
module sfcf_dev
	import sfcf_pkg::*;
#(
	parameter logic [7:0]  MFR_ID  = 8'hA5,   // Arbitrary value
	parameter logic [7:0]  DEV_ID  = 8'h3C,   // Arbitrary value
	parameter logic [15:0] JDEV_ID = 16'h5A19 // Arbitrary value
) (
	sfcf_if.dev         link,
	input  wire logic        ref_clk_i,
	input  wire logic        srst_i,
	input  wire logic [7:0]  rd_data_i,
	output logic             cmd_valid_o,
	output logic             cmd_reject_o,
	output logic [7:0]       cmd_op_o,
	output logic [23:0]      cmd_addr_o,
	output logic [7:0]       cmd_data_o,
	output logic             write_enable_latch_o,
	output logic             pwr_down_o
);
`include "sfcf_map.svh"

	// ==========================================================
	// Link side, rising edges
	logic        active_reg;
	logic [5:0]  edge_cnt_reg;
	logic [2:0]  bitmod_reg;
	logic [3:0]  byte_cnt_reg;
	logic [7:0]  shift_reg;
	logic [7:0]  opcode_reg;
	logic [31:0] addr_reg;
	logic [7:0]  data_reg;
	logic        dout_reg;
	logic [1:0]  latch_sync_reg;
	logic [1:0]  pd_sync_reg;
	logic [7:0]  rd_m_reg;
	logic [7:0]  rd_s_reg;

	wire [5:0] edge_next   = !active_reg ? 6'd1 :
	                         (&edge_cnt_reg ? edge_cnt_reg : edge_cnt_reg + 6'd1);
	wire [2:0] bitmod_next = active_reg ? bitmod_reg + 3'd1 : 3'd1;
	wire       byte_done   = (bitmod_next == 3'd0);
	wire [3:0] byte_next   = !active_reg ? 4'd0 :
	                         ((byte_done && !(&byte_cnt_reg)) ? byte_cnt_reg + 4'd1 : byte_cnt_reg);
	wire [7:0] shift_next  = {shift_reg[6:0], link.io[0]};
	wire [7:0] op_cur      = (edge_next == `SFCF_HDR_OPC) ? shift_next : opcode_reg;
	wire       op_x2       = (opcode_reg == `SFCF_OP_MFR_ID_X2);
	wire       op_x4       = (opcode_reg == `SFCF_OP_MFR_ID_X4);

	// Address windows by lane count
	wire in_a1 = !op_x2 && !op_x4 && edge_next > `SFCF_HDR_OPC && edge_next <= `SFCF_ADR1_END;
	wire in_a2 = op_x2 && edge_next > `SFCF_HDR_OPC && edge_next <= `SFCF_ADR2_END;
	wire in_a4 = op_x4 && edge_next > `SFCF_HDR_OPC && edge_next <= `SFCF_ADR4_END;
	wire [31:0] addr_next = in_a4 ? {addr_reg[27:0], link.io[3:0]} :
	                        in_a2 ? {addr_reg[29:0], link.io[1:0]} :
	                        in_a1 ? {addr_reg[30:0], link.io[0]}   : addr_reg;

	// Output header length per read opcode; zero marks a non-read
	logic [5:0] hdr_len;
	always_comb begin
		case (op_cur)
			`SFCF_OP_ST_RD, `SFCF_OP_ST_RD_HI, `SFCF_OP_JEDEC_ID: hdr_len = `SFCF_HDR_OPC;
			`SFCF_OP_RD, `SFCF_OP_MFR_ID, `SFCF_OP_WAKE_ID:       hdr_len = `SFCF_HDR_ADDR;
			`SFCF_OP_RD_FAST:                                     hdr_len = `SFCF_HDR_FAST;
			`SFCF_OP_MFR_ID_X2:                                   hdr_len = `SFCF_HDR_X2;
			`SFCF_OP_MFR_ID_X4:                                   hdr_len = `SFCF_HDR_X4;
			default:                                              hdr_len = 6'd0;
		endcase
	end
	// While powered down only the wake command answers
	wire rd_ok     = (hdr_len != 6'd0) && (!pd_sync_reg[1] || op_cur == `SFCF_OP_WAKE_ID);
	wire dout_next = rd_ok && edge_next >= hdr_len;

	// Frame flag: the only rising-edge state cleared by select; the counters and opcode restart at the first edge
	always_ff @(posedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			active_reg <= 1'b0;
		end else begin
			active_reg <= 1'b1;
		end
	end

	// Bit, byte and phase tracking
	always_ff @(posedge link.sclk) begin
		edge_cnt_reg <= edge_next;
		bitmod_reg   <= bitmod_next;
		byte_cnt_reg <= byte_next;
		shift_reg    <= shift_next;
		opcode_reg   <= !active_reg ? `SFCF_OP_NOP :
		                ((edge_next == `SFCF_HDR_OPC) ? shift_next : opcode_reg);
		addr_reg     <= addr_next;
		dout_reg     <= dout_next;
		if (byte_done && edge_next > `SFCF_HDR_OPC) begin
			data_reg <= shift_next;
		end
	end

	// Levels from the reference side; latch and power-down only change between frames
	always_ff @(posedge link.sclk) begin
		latch_sync_reg <= {latch_sync_reg[0], write_enable_latch_o};
		pd_sync_reg    <= {pd_sync_reg[0], pwr_down_o};
		rd_m_reg     <= rd_data_i;
		rd_s_reg     <= rd_m_reg;
	end

	// ==========================================================
	// Link side, falling edges: output shifter
	logic [7:0] tx_shift_reg;
	logic [1:0] tx_pos_reg;
	logic [1:0] tx_idx_reg;
	logic [3:0] io_o_reg;
	logic [3:0] io_oe_reg;

	wire [7:0] status_lo = {6'h00, latch_sync_reg[1], 1'b0};
	logic [7:0] tx_byte;
	logic [1:0] tx_cyc;
	always_comb begin
		tx_cyc = 2'd1;
		case (opcode_reg)
			`SFCF_OP_ST_RD:              tx_byte = status_lo;
			`SFCF_OP_ST_RD_HI:           tx_byte = 8'h00;
			`SFCF_OP_RD, `SFCF_OP_RD_FAST: tx_byte = rd_s_reg;
			`SFCF_OP_WAKE_ID:            tx_byte = DEV_ID;
			`SFCF_OP_JEDEC_ID: begin
				tx_cyc  = 2'd3;
				tx_byte = (tx_idx_reg == 2'd0) ? MFR_ID :
				          ((tx_idx_reg == 2'd1) ? JDEV_ID[15:8] : JDEV_ID[7:0]);
			end
			`SFCF_OP_MFR_ID, `SFCF_OP_MFR_ID_X2, `SFCF_OP_MFR_ID_X4: begin
				tx_cyc  = 2'd2;
				tx_byte = (tx_idx_reg == 2'd0) ? MFR_ID : DEV_ID;
			end
			default:                     tx_byte = 8'hFF;
		endcase
	end

	wire [7:0] tx_cur   = (tx_pos_reg == 2'd0) ? tx_byte : tx_shift_reg;
	wire       tx_last  = op_x4 ? (tx_pos_reg == 2'd1) :
	                      (op_x2 ? (tx_pos_reg == 2'd3) : 1'b0);
	wire [3:0] tx_pins  = op_x4 ? tx_cur[7:4] :
	                      (op_x2 ? {2'b00, tx_cur[7:6]} : {2'b00, tx_cur[7], 1'b0});
	wire [3:0] tx_mask  = op_x4 ? 4'hF : (op_x2 ? 4'h3 : 4'h2);
	wire [7:0] tx_shl   = op_x4 ? {tx_cur[3:0], 4'h0} :
	                      (op_x2 ? {tx_cur[5:0], 2'b00} : {tx_cur[6:0], 1'b0});
	wire [1:0] idx_inc  = (tx_idx_reg + 2'd1 >= tx_cyc) ? 2'd0 : tx_idx_reg + 2'd1;

	// Single lane counts 8 bits with a 3-bit position kept in its own register, tx_bit_reg
	logic [2:0] tx_bit_reg;
	wire        tx_load = op_x2 || op_x4 ? (tx_pos_reg == 2'd0) : (tx_bit_reg == 3'd0);
	wire [7:0]  tx_src  = (op_x2 || op_x4) ? tx_cur : (tx_load ? tx_byte : tx_shift_reg);
	wire [3:0]  tx_drv  = (op_x2 || op_x4) ? tx_pins : {2'b00, tx_src[7], 1'b0};

	always_ff @(negedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			tx_shift_reg <= 8'h00;
			tx_pos_reg   <= 2'd0;
			tx_bit_reg   <= 3'd0;
			tx_idx_reg   <= 2'd0;
			io_o_reg     <= 4'h0;
			io_oe_reg    <= 4'h0;
		end else if (dout_reg) begin
			io_o_reg     <= tx_drv;
			io_oe_reg    <= tx_mask;
			tx_shift_reg <= (op_x2 || op_x4) ? tx_shl : {tx_src[6:0], 1'b0};
			tx_pos_reg   <= tx_last ? 2'd0 : tx_pos_reg + 2'd1;
			tx_bit_reg   <= tx_bit_reg + 3'd1;
			if (tx_load) begin
				tx_idx_reg <= idx_inc;
			end
		end else begin
			io_oe_reg <= 4'h0;
		end
	end
	assign link.dev_io_o  = io_o_reg;
	assign link.dev_io_oe = io_oe_reg;

	// ==========================================================
	// Reference side: select release and command execution
	logic [2:0] cs_sync_reg;
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			cs_sync_reg <= 3'b111;
		end else begin
			cs_sync_reg <= {cs_sync_reg[1:0], link.cs_n};
		end
	end
	// Frame summary is stable here: the clock has stopped since select rose
	wire cs_rise = cs_sync_reg[1] && !cs_sync_reg[2];
	wire whole   = (bitmod_reg == 3'd0);
	logic       is_mod;
	logic [3:0] min_len;
	always_comb begin
		is_mod  = 1'b1;
		min_len = `SFCF_LEN_OPC;
		case (opcode_reg)
			`SFCF_OP_PROG:                         min_len = `SFCF_LEN_PROG;
			`SFCF_OP_SEC_ERASE, `SFCF_OP_BLK32_ERA,
			`SFCF_OP_BLK64_ERA:                    min_len = `SFCF_LEN_ERASE;
			`SFCF_OP_ST_WR:                        min_len = `SFCF_LEN_ST_WR;
			`SFCF_OP_CHIP_ERA_A, `SFCF_OP_CHIP_ERA_B: min_len = `SFCF_LEN_OPC;
			default:                               is_mod  = 1'b0;
		endcase
	end
	wire is_simple = (opcode_reg == `SFCF_OP_WR_EN) || (opcode_reg == `SFCF_OP_WR_DIS) ||
	                 (opcode_reg == `SFCF_OP_PWR_DOWN);
	wire frame_ok  = cs_rise && whole && !pwr_down_o && byte_cnt_reg >= min_len;
	wire run_mod   = frame_ok && is_mod && write_enable_latch_o;
	wire run_simp  = frame_ok && is_simple;
	wire wake      = cs_rise && opcode_reg == `SFCF_OP_WAKE_ID && byte_cnt_reg != 4'd0;
	wire refuse    = cs_rise && (is_mod || is_simple) && !run_mod && !run_simp;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			write_enable_latch_o <= 1'b0;
			pwr_down_o           <= 1'b0;
			cmd_valid_o          <= 1'b0;
			cmd_reject_o         <= 1'b0;
			cmd_op_o             <= 8'h00;
			cmd_addr_o           <= 24'h000000;
			cmd_data_o           <= 8'h00;
		end else begin
			cmd_valid_o  <= run_mod;
			cmd_reject_o <= refuse;
			if (run_mod) begin
				cmd_op_o             <= opcode_reg;
				cmd_addr_o           <= addr_reg[23:0];
				cmd_data_o           <= data_reg;
				write_enable_latch_o <= 1'b0;
			end else if (run_simp && opcode_reg == `SFCF_OP_WR_EN) begin
				write_enable_latch_o <= 1'b1;
			end else if (run_simp && opcode_reg == `SFCF_OP_WR_DIS) begin
				write_enable_latch_o <= 1'b0;
			end
			if (run_simp && opcode_reg == `SFCF_OP_PWR_DOWN) begin
				pwr_down_o <= 1'b1;
			end else if (wake) begin
				pwr_down_o <= 1'b0;
			end
		end
	end
endmodule : sfcf_dev

// >>> core/sfcf_map.svh
`ifndef SFCF_MAP_SVH
`define SFCF_MAP_SVH
// ==========================================================
// Opcodes
`define SFCF_OP_NOP        8'h00
`define SFCF_OP_WR_EN      8'h06
`define SFCF_OP_WR_DIS     8'h04
`define SFCF_OP_ST_RD      8'h05
`define SFCF_OP_ST_RD_HI   8'h35
`define SFCF_OP_ST_WR      8'h01
`define SFCF_OP_RD         8'h03
`define SFCF_OP_RD_FAST    8'h0B
`define SFCF_OP_PROG       8'h02
`define SFCF_OP_SEC_ERASE  8'h20
`define SFCF_OP_BLK32_ERA  8'h52
`define SFCF_OP_BLK64_ERA  8'hD8
`define SFCF_OP_CHIP_ERA_A 8'hC7
`define SFCF_OP_CHIP_ERA_B 8'h60
`define SFCF_OP_PWR_DOWN   8'hB9
`define SFCF_OP_WAKE_ID    8'hAB
`define SFCF_OP_MFR_ID     8'h90
`define SFCF_OP_MFR_ID_X2  8'h92
`define SFCF_OP_MFR_ID_X4  8'h94
`define SFCF_OP_JEDEC_ID   8'h9F
// ==========================================================
// Rising edges before the first output bit
`define SFCF_HDR_OPC       6'd8
`define SFCF_HDR_ADDR      6'd32
`define SFCF_HDR_FAST      6'd40
`define SFCF_HDR_X2        6'd24
`define SFCF_HDR_X4        6'd20
// Address window ends (edge index, inclusive)
`define SFCF_ADR1_END      6'd32
`define SFCF_ADR2_END      6'd24
`define SFCF_ADR4_END      6'd16
// Least whole bytes before a modifying command may run
`define SFCF_LEN_OPC       4'd1
`define SFCF_LEN_ST_WR     4'd2
`define SFCF_LEN_ERASE     4'd4
`define SFCF_LEN_PROG      4'd5
// ==========================================================
// Timing
`define SFCF_REF_PERIOD_NS 40
`define SFCF_CSH_MIN_NS    50
`define SFCF_CSH_CYC       ((`SFCF_CSH_MIN_NS + `SFCF_REF_PERIOD_NS - 1) / `SFCF_REF_PERIOD_NS)
`endif

// >>> core/sfcf_pkg.sv
package sfcf_pkg;
	// Host sequencer states
	typedef enum logic [1:0] {
		SFCF_H_IDLE = 2'b00,
		SFCF_H_RUN  = 2'b01,
		SFCF_H_END  = 2'b10
	} sfcf_host_state_t;
endpackage : sfcf_pkg

// >>> core/sfcf_if.sv
`timescale 1ns/1ps
interface sfcf_if;
	logic       cs_n;
	logic       sclk;
	logic [3:0] host_io_o;
	logic [3:0] host_io_oe;
	logic [3:0] dev_io_o;
	logic [3:0] dev_io_oe;
	logic [3:0] io;
	// Resolved line level; an undriven line reads high as if pulled up
	genvar g;
	for (g = 0; g < 4; g++) begin : g_res
		assign io[g] = host_io_oe[g] ? host_io_o[g] : (dev_io_oe[g] ? dev_io_o[g] : 1'b1);
	end
	modport host (output cs_n, output sclk, output host_io_o, output host_io_oe, input io);
	modport dev  (input cs_n, input sclk, input io, output dev_io_o, output dev_io_oe);
endinterface : sfcf_if

// >>> core/sfcf_host.sv
`timescale 1ns/1ps
module sfcf_host
	import sfcf_pkg::*;
#(
	parameter int SCLK_HALF = 4 // Reference cycles per half link clock, at least 3
) (
	sfcf_if.host              link,
	input  wire logic         ref_clk_i,
	input  wire logic         srst_i,
	input  wire logic         start_i,
	input  wire logic [7:0]   opcode_i,
	input  wire logic [39:0]  tx_word_i,
	input  wire logic [5:0]   tx_bits_i,
	input  wire logic [2:0]   tx_lanes_i,
	input  wire logic [3:0]   dummy_clks_i,
	input  wire logic [7:0]   rx_bytes_i,
	input  wire logic [2:0]   rx_lanes_i,
	output logic              busy_o,
	output logic              done_o,
	output logic              rx_valid_o,
	output logic [7:0]        rx_data_o
);
`include "sfcf_map.svh"

	// ==========================================================
	// State
	sfcf_host_state_t state_reg;
	logic [7:0]  half_reg;
	logic        sclk_reg;
	logic        cs_n_reg;
	logic [11:0] k_reg;
	logic [47:0] tx_reg;
	logic [3:0]  io_o_reg;
	logic [3:0]  io_oe_reg;
	logic [5:0]  tx_bits_reg;
	logic [2:0]  tx_lanes_reg;
	logic [3:0]  dummy_reg;
	logic [7:0]  rx_bytes_reg;
	logic [2:0]  rx_lanes_reg;
	logic [7:0]  rx_sh_reg;
	logic [3:0]  rx_cnt_reg;
	logic [3:0]  io_m_reg;
	logic [3:0]  io_s_reg;

	// ==========================================================
	// Phase boundaries in rising-edge indices
	wire [1:0]  tsh     = (tx_lanes_reg == 3'd4) ? 2'd2 : ((tx_lanes_reg == 3'd2) ? 2'd1 : 2'd0);
	wire [1:0]  rsh     = (rx_lanes_reg == 3'd4) ? 2'd2 : ((rx_lanes_reg == 3'd2) ? 2'd1 : 2'd0);
	wire [11:0] adr_end = 12'd8 + {6'd0, tx_bits_reg >> tsh};
	wire [11:0] dmy_end = adr_end + {8'd0, dummy_reg};
	wire [11:0] total   = dmy_end + ({1'b0, rx_bytes_reg, 3'b000} >> rsh);
	wire        tick    = (half_reg == 8'(SCLK_HALF - 1));

	// Drive for the edge that the counter now names
	wire        d_opc   = (k_reg < 12'd8);
	wire        d_adr   = !d_opc && k_reg < adr_end;
	wire [2:0]  d_lanes = d_opc ? 3'd1 : tx_lanes_reg;
	wire [3:0]  d_pins  = (d_lanes == 3'd4) ? tx_reg[47:44] :
	                      ((d_lanes == 3'd2) ? {2'b00, tx_reg[47:46]} : {3'b000, tx_reg[47]});
	wire [3:0]  d_mask  = !(d_opc || d_adr) ? 4'h0 :
	                      ((d_lanes == 3'd4) ? 4'hF : ((d_lanes == 3'd2) ? 4'h3 : 4'h1));
	wire [47:0] tx_shl  = (d_lanes == 3'd4) ? {tx_reg[43:0], 4'h0} :
	                      ((d_lanes == 3'd2) ? {tx_reg[45:0], 2'b00} : {tx_reg[46:0], 1'b0});

	// Sample on rising edges in the read window
	wire        s_rd    = (k_reg >= dmy_end) && (k_reg < total);
	wire [7:0]  rx_next = (rx_lanes_reg == 3'd4) ? {rx_sh_reg[3:0], io_s_reg} :
	                      ((rx_lanes_reg == 3'd2) ? {rx_sh_reg[5:0], io_s_reg[1:0]} :
	                       {rx_sh_reg[6:0], io_s_reg[1]});
	wire [3:0]  rx_cnt_n = rx_cnt_reg + {1'b0, rx_lanes_reg};

	// Pins from the device pass two flip-flops
	always_ff @(posedge ref_clk_i) begin
		io_m_reg <= link.io;
		io_s_reg <= io_m_reg;
	end

	// ==========================================================
	// Sequencer
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			state_reg  <= SFCF_H_IDLE;
			half_reg   <= 8'd0;
			sclk_reg   <= 1'b0;
			cs_n_reg   <= 1'b1;
			k_reg      <= 12'd0;
			tx_reg     <= 48'd0;
			io_o_reg   <= 4'h0;
			io_oe_reg  <= 4'h0;
			rx_sh_reg  <= 8'h00;
			rx_cnt_reg <= 4'd0;
			rx_valid_o <= 1'b0;
			rx_data_o  <= 8'h00;
			done_o     <= 1'b0;
			busy_o     <= 1'b0;
			tx_bits_reg  <= 6'd0;
			tx_lanes_reg <= 3'd1;
			dummy_reg    <= 4'd0;
			rx_bytes_reg <= 8'd0;
			rx_lanes_reg <= 3'd1;
		end else begin
			rx_valid_o <= 1'b0;
			done_o     <= 1'b0;
			half_reg   <= tick ? 8'd0 : half_reg + 8'd1;
			case (state_reg)
				SFCF_H_IDLE: begin
					half_reg <= 8'd0;
					if (start_i) begin
						// Select falls with the opcode MSB already on the line
						state_reg    <= SFCF_H_RUN;
						busy_o       <= 1'b1;
						cs_n_reg     <= 1'b0;
						k_reg        <= 12'd0;
						tx_reg       <= {opcode_i[6:0], tx_word_i, 1'b0};
						io_o_reg     <= {3'b000, opcode_i[7]};
						io_oe_reg    <= 4'h1;
						tx_bits_reg  <= tx_bits_i;
						tx_lanes_reg <= tx_lanes_i;
						dummy_reg    <= dummy_clks_i;
						rx_bytes_reg <= rx_bytes_i;
						rx_lanes_reg <= rx_lanes_i;
						rx_cnt_reg   <= 4'd0;
					end
				end
				SFCF_H_RUN: begin
					if (tick && !sclk_reg) begin
						if (k_reg == total) begin
							// Select rises only after the last clock
							state_reg <= SFCF_H_END;
							cs_n_reg  <= 1'b1;
							io_oe_reg <= 4'h0;
						end else begin
							sclk_reg <= 1'b1;
							k_reg    <= k_reg + 12'd1;
							if (s_rd) begin
								rx_sh_reg  <= rx_next;
								rx_cnt_reg <= (rx_cnt_n == 4'd8) ? 4'd0 : rx_cnt_n;
								rx_valid_o <= (rx_cnt_n == 4'd8);
								rx_data_o  <= rx_next;
							end
						end
					end else if (tick) begin
						sclk_reg  <= 1'b0;
						io_o_reg  <= d_pins;
						io_oe_reg <= d_mask;
						if (d_opc || d_adr) begin
							tx_reg <= tx_shl;
						end
					end
				end
				SFCF_H_END: begin
					if (half_reg == 8'(`SFCF_CSH_CYC)) begin
						state_reg <= SFCF_H_IDLE;
						busy_o    <= 1'b0;
						done_o    <= 1'b1;
					end
				end
				default: state_reg <= SFCF_H_IDLE;
			endcase
		end
	end

	assign link.cs_n       = cs_n_reg;
	assign link.sclk       = sclk_reg;
	assign link.host_io_o  = io_o_reg;
	assign link.host_io_oe = io_oe_reg;
endmodule : sfcf_host

// >>> bench/sfcf_properties.sv
`timescale 1ns/1ps
// ==========================================================
// Checks on the wire between the host end and the device end
module sfcf_properties (
	input wire logic       ref_clk_i,
	input wire logic       srst_i,
	input wire logic       cs_n,
	input wire logic       sclk,
	input wire logic [3:0] host_io_oe,
	input wire logic [3:0] dev_io_o,
	input wire logic [3:0] dev_io_oe
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	logic       sclk_reg;
	logic [7:0] rise_cnt_reg;
	logic [7:0] rise_cnt_next;

	// ==========================================================
	// Rising link edges in the frame; saturates so long reads never wrap
	assign rise_cnt_next = cs_n ? 8'h00 :
		((sclk && !sclk_reg && rise_cnt_reg != 8'hFF) ? rise_cnt_reg + 8'h01 : rise_cnt_reg);
	always_ff @(posedge ref_clk_i) begin
		sclk_reg     <= sclk;
		rise_cnt_reg <= rise_cnt_next;
	end

	// ==========================================================
	// Properties
	a_idle_no_drive: assert property (cs_n |-> dev_io_oe == 4'h0)
		else $error("device drives the link while deselected");
	a_sclk_idle_low: assert property (cs_n |-> !sclk)
		else $error("link clock not low while deselected");
	a_first_edge_rise: assert property ($fell(cs_n) |-> !sclk [*2])
		else $error("link clock not low after select falls");
	a_opcode_on_si: assert property ($fell(cs_n) |-> host_io_oe[0])
		else $error("serial input not driven at frame start");
	a_no_contention: assert property ((host_io_oe & dev_io_oe) == 4'h0)
		else $error("both ends drive one line");
	a_quiet_opcode: assert property (!cs_n && rise_cnt_reg < 8'h08 |-> dev_io_oe == 4'h0)
		else $error("device drives during the opcode byte");
	a_change_on_fall: assert property (!cs_n && dev_io_oe != 4'h0 && $changed(dev_io_o)
		|-> !sclk)
		else $error("device output changed while link clock high");
	a_drive_holds: assert property (!cs_n && dev_io_oe != 4'h0 |=> cs_n || dev_io_oe != 4'h0)
		else $error("device released the line within a read");
	a_release_low: assert property ($rose(cs_n) |-> !sclk && !$past(sclk))
		else $error("select rose with link clock high");
	a_select_gap: assert property ($rose(cs_n) |-> cs_n [*3])
		else $error("select high time too short");
endmodule : sfcf_properties

// >>> bench/tb_serial_flash_command_frontend.sv
`timescale 1ns/1ps
module tb_serial_flash_command_frontend
	import sfcf_pkg::*;
;
	localparam logic [7:0]  MFR  = 8'h96;    // Arbitrary value
	localparam logic [7:0]  DEVI = 8'h4B;    // Arbitrary value
	localparam logic [15:0] JDEV = 16'hC3E1; // Arbitrary value

	logic        ref_clk_i;
	logic        srst_i;
	logic        start_i;
	logic [7:0]  opcode_i;
	logic [39:0] tx_word_i;
	logic [5:0]  tx_bits_i;
	logic [2:0]  tx_lanes_i;
	logic [3:0]  dummy_clks_i;
	logic [7:0]  rx_bytes_i;
	logic [2:0]  rx_lanes_i;
	logic [7:0]  rd_data_i;
	logic        busy_o;
	logic        done_o;
	logic        rx_valid_o;
	logic [7:0]  rx_data_o;
	logic        cmd_valid_o;
	logic        cmd_reject_o;
	logic [7:0]  cmd_op_o;
	logic [23:0] cmd_addr_o;
	logic [7:0]  cmd_data_o;
	logic        write_enable_latch_o;
	logic        pwr_down_o;
	logic [1:0]  ev;
	logic [7:0]  rxq[$];
	int          mismatches;
	int          checked;
	int          i;
	logic [7:0]  mod_op   [6] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h01};
	logic [5:0]  mod_bits [6] = '{6'd24, 6'd24, 6'd24, 6'd0, 6'd0, 6'd16};
	logic [7:0]  id_op    [3] = '{8'h90, 8'h92, 8'h94};
	logic [5:0]  id_bits  [3] = '{6'd24, 6'd32, 6'd32};
	logic [2:0]  id_lanes [3] = '{3'd1, 3'd2, 3'd4};
	logic [3:0]  id_dum   [3] = '{4'h0, 4'h0, 4'h4};

	sfcf_if link ();

	sfcf_host i_sfcf_host (.link(link), .ref_clk_i(ref_clk_i), .srst_i(srst_i),
		.start_i(start_i), .opcode_i(opcode_i), .tx_word_i(tx_word_i), .tx_bits_i(tx_bits_i),
		.tx_lanes_i(tx_lanes_i), .dummy_clks_i(dummy_clks_i), .rx_bytes_i(rx_bytes_i),
		.rx_lanes_i(rx_lanes_i), .busy_o(busy_o), .done_o(done_o), .rx_valid_o(rx_valid_o),
		.rx_data_o(rx_data_o));

	sfcf_dev #(.MFR_ID(MFR), .DEV_ID(DEVI), .JDEV_ID(JDEV)) i_sfcf_dev (.link(link),
		.ref_clk_i(ref_clk_i), .srst_i(srst_i), .rd_data_i(rd_data_i),
		.cmd_valid_o(cmd_valid_o), .cmd_reject_o(cmd_reject_o), .cmd_op_o(cmd_op_o),
		.cmd_addr_o(cmd_addr_o), .cmd_data_o(cmd_data_o),
		.write_enable_latch_o(write_enable_latch_o), .pwr_down_o(pwr_down_o));

	sfcf_properties i_sfcf_properties (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
		.cs_n(link.cs_n), .sclk(link.sclk), .host_io_oe(link.host_io_oe),
		.dev_io_o(link.dev_io_o), .dev_io_oe(link.dev_io_oe));

	// ==========================================================
	// Clock and capture of received bytes and command decisions
	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		if (rx_valid_o === 1'b1) rxq.push_back(rx_data_o);
		if (cmd_valid_o === 1'b1) ev = 2'd1;
		if (cmd_reject_o === 1'b1) ev = 2'd2;
	end

	// ==========================================================
	// Tasks
	task automatic finish_test;
		if (mismatches == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [7:0] rxb(input int n);
		return (n < rxq.size()) ? rxq[n] : 8'hXX;
	endfunction : rxb

	// One whole frame; entered at a clock edge, leaves at one after the gap
	task automatic run(input logic [7:0] op, input logic [39:0] w, input logic [5:0] b,
		input logic [2:0] tl, input logic [3:0] dc, input logic [7:0] n, input logic [2:0] rl);
		int k;
		rxq.delete();
		ev = 2'd0;
		opcode_i     <= op;
		tx_word_i    <= w;
		tx_bits_i    <= b;
		tx_lanes_i   <= tl;
		dummy_clks_i <= dc;
		rx_bytes_i   <= n;
		rx_lanes_i   <= rl;
		start_i      <= 1'b1;
		@(posedge ref_clk_i);
		start_i <= 1'b0;
		k = 0;
		do begin
			@(posedge ref_clk_i);
			#1;
			k++;
		end while (done_o !== 1'b1 && k < 4000);
		if (k >= 4000) begin
			mismatches++;
			finish_test();
		end
		// Decision pulses trail the select release by a few cycles
		repeat (8) @(posedge ref_clk_i);
	endtask : run

	// ==========================================================
	// Main sequence
	initial begin
		mismatches = 0;
		checked = 0;
		srst_i = 1'b1;
		start_i = 1'b0;
		opcode_i = 8'h00;
		tx_word_i = 40'h0;
		tx_bits_i = 6'd0;
		tx_lanes_i = 3'd1;
		dummy_clks_i = 4'h0;
		rx_bytes_i = 8'h00;
		rx_lanes_i = 3'd1;
		rd_data_i = 8'hC3;
		repeat (16) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		run(8'h05, 40'h0, 6'd0, 3'd1, 4'h0, 8'h01, 3'd1);
		chk(24'(rxb(0)), 24'h0);
		chk(24'(link.io), 24'hF);
		chk(24'(busy_o), 24'h0);
		run(8'h00, 40'h0, 6'd0, 3'd1, 4'h0, 8'h00, 3'd1);
		chk(24'(ev), 24'h0);
		run(8'h02, 40'h0102031100, 6'd32, 3'd1, 4'h0, 8'h00, 3'd1);
		chk(24'(ev), 24'h2);
		run(8'h06, 40'h0, 6'd0, 3'd1, 4'h0, 8'h00, 3'd1);
		chk(24'(write_enable_latch_o), 24'h1);
		run(8'h05, 40'h0, 6'd0, 3'd1, 4'h0, 8'h02, 3'd1);
		chk(24'({rxb(0), rxb(1)}), 24'h0202);
		// Upper status byte reads as zero, not as the floating line
		run(8'h35, 40'h0, 6'd0, 3'd1, 4'h0, 8'h01, 3'd1);
		chk(24'(rxb(0)), 24'h0);
		// Program cut three bits into a byte: dropped, latch kept
		run(8'h02, 40'h123456A700, 6'd35, 3'd1, 4'h0, 8'h00, 3'd1);
		chk(24'(ev), 24'h2);
		chk(24'(write_enable_latch_o), 24'h1);
		run(8'h02, 40'h1234565A00, 6'd32, 3'd1, 4'h0, 8'h00, 3'd1);
		chk(24'(ev), 24'h1);
		chk({cmd_op_o, cmd_data_o, 8'h00}, 24'h025A00);
		chk(cmd_addr_o, 24'h123456);
		chk(24'(write_enable_latch_o), 24'h0);
		for (i = 0; i < 6; i++) begin
			run(8'h06, 40'h0, 6'd0, 3'd1, 4'h0, 8'h00, 3'd1);
			run(mod_op[i], 40'hABCDEF7700, mod_bits[i], 3'd1, 4'h0, 8'h00, 3'd1);
			chk(24'({ev, cmd_op_o}), 24'({2'd1, mod_op[i]}));
			if (i < 3) chk(cmd_addr_o, 24'hABCDEF);
		end
		// Status write ran last: its third byte is the last whole one
		chk(24'(cmd_data_o), 24'hCD);
		// Write enable with one stray clock is refused
		run(8'h06, 40'h8000000000, 6'd1, 3'd1, 4'h0, 8'h00, 3'd1);
		chk(24'({ev, write_enable_latch_o}), 24'h4);
		run(8'h06, 40'h0, 6'd0, 3'd1, 4'h0, 8'h00, 3'd1);
		run(8'h04, 40'h0, 6'd0, 3'd1, 4'h0, 8'h00, 3'd1);
		chk(24'(write_enable_latch_o), 24'h0);
		run(8'h9F, 40'h0, 6'd0, 3'd1, 4'h0, 8'h06, 3'd1);
		for (i = 0; i < 6; i++)
			chk(24'(rxb(i)), 24'((i % 3 == 0) ? MFR : ((i % 3 == 1) ? JDEV[15:8] : JDEV[7:0])));
		for (i = 0; i < 3; i++) begin
			run(id_op[i], 40'h0, id_bits[i], id_lanes[i], id_dum[i], 8'h04, id_lanes[i]);
			chk(24'({rxb(0), rxb(1), rxb(2)}), {MFR, DEVI, MFR});
			chk(24'(rxb(3)), 24'(DEVI));
		end
		run(8'h03, 40'h00F0000000, 6'd24, 3'd1, 4'h0, 8'h02, 3'd1);
		chk(24'({rxb(0), rxb(1)}), 24'hC3C3);
		rd_data_i <= 8'h3C;
		run(8'h0B, 40'h00F0000000, 6'd24, 3'd1, 4'h8, 8'h02, 3'd1);
		chk(24'({rxb(0), rxb(1)}), 24'h3C3C);
		run(8'hB9, 40'h0, 6'd0, 3'd1, 4'h0, 8'h00, 3'd1);
		chk(24'(pwr_down_o), 24'h1);
		// Powered down: the line floats to its pull-up level
		run(8'h9F, 40'h0, 6'd0, 3'd1, 4'h0, 8'h01, 3'd1);
		chk(24'(rxb(0)), 24'hFF);
		run(8'hAB, 40'h0, 6'd24, 3'd1, 4'h0, 8'h02, 3'd1);
		chk(24'({rxb(0), rxb(1), 7'h0, pwr_down_o}), {DEVI, DEVI, 8'h00});
		finish_test();
	end
endmodule : tb_serial_flash_command_frontend
